// File: design/gpib_status_poll.sv
// Purpose: Status byte, service request summary and bus-command handling.
// Assumes: Commands arrive as one-cycle strobes from a decoder on sys_clk.
// Notes:   Status conditions are level inputs from the same clock domain.
`timescale 1ns/1ps
`include "status_poll_defs.svh"

// Functional notes
// - Enable mask reads bit 6 as zero
// - Status read substitutes summary in bit 6
// - Summary is OR of masked status bits
// - Bits 1-3: device, error queue, questionable
// - Bits 4,5,7: message, event, operation
// - Triggers fire all waiting channels
// - Non-bus trigger source: ignore, queue -211
// - No channel waiting: ignore, queue -211
// - Self test runs, then queues pass/fail
// - Wait holds commands until done or clear
// - Clear aborts waits, resets parser, flushes output
// - Selected clear only when listen-addressed
// - Go-to-local: local, panel on, free run
// - Lockout disables local key until controller
// - Configure while listening arms enable byte
// - Enable byte picks line and sense
// - Configure plus disable byte stops responses
// - Unconfigure stops all parallel poll responses
// - Serial poll sends one status byte
// - Serial poll disable restores normal data
// - Mask bit set enables matching status bit
module gpib_status_poll #(
    // 64-bit product: the long test count does not fit in 32 bits
    parameter longint unsigned TST_CYCLES     = 64'(`TST_TIME_S) * 64'(`CLK_HZ),
    parameter longint unsigned TST_USB_CYCLES = 64'(`TST_TIME_USB_S) * 64'(`CLK_HZ)
) (
    // Clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  resetn,
    // Command port
    input  wire status_poll_pkg::cmd_t cmd,
    input  wire logic            [7:0] cmdData,
    input  wire logic                  listenAddr,
    input  wire logic                  talkAddr,
    input  wire logic                  secValid,
    input  wire logic            [7:0] secByte,
    // Status conditions
    input  wire logic                  devDepCond,
    input  wire logic                  errQueueNotEmpty,
    input  wire logic                  quesSummary,
    input  wire logic                  msgAvailable,
    input  wire logic                  eventSummary,
    input  wire logic                  operSummary,
    // Measurement side
    input  wire logic                  trigSourceBus,
    input  wire logic  [`NUM_CHAN-1:0] chanWaiting,
    input  wire logic                  opsPending,
    input  wire logic                  usbOption,
    input  wire logic                  testFail,
    input  wire logic                  talkReq,
    input  wire logic            [7:0] devData,
    // Results
    output logic                       replyValid,
    output logic                 [7:0] replyData,
    output logic                       talkValid,
    output logic                 [7:0] talkData,
    output logic       [`NUM_CHAN-1:0] chanTrigger,
    output logic                       errPush,
    output logic                [15:0] errCode,
    output logic                       cmdHold,
    output logic                       parserReset,
    output logic                       outFlush,
    output logic                       abortOps,
    output logic                       remoteMode,
    output logic                       localKeyLocked,
    output logic                       freeRun,
    output logic                       srqPending,
    // Parallel poll
    input  wire logic                  pollActive,
    output logic                 [7:0] ppData,
    output logic                 [7:0] ppOen
);
    import status_poll_pkg::*;

    typedef struct packed {
        logic [7:0]           service_request_enable;
        exec_t                exec;
        logic [32:0]          cnt;
        logic                 replyValid;
        logic [7:0]           replyData;
        logic                 talkValid;
        logic [7:0]           talkData;
        logic                 serialPoll;
        logic                 spSent;
        logic [`NUM_CHAN-1:0] chanTrigger;
        logic                 errPush;
        logic [15:0]          errCode;
        logic                 parserReset;
        logic                 outFlush;
        logic                 abortOps;
        logic                 remote;
        logic                 locked;
        logic                 freeRun;
        logic                 mss;
        logic                 hold;
    } state_t;

    state_t cur_ff;
    state_t nxt_cur;
    logic [7:0] stb;
    logic       mss;
    logic       clearHit;

    always_comb begin
        stb = 8'h00;
        stb[`DEPDEV_BIT] = devDepCond;
        stb[`ERRQ_BIT] = errQueueNotEmpty;
        stb[`QUES_BIT] = quesSummary;
        stb[`MAV_BIT] = msgAvailable;
        stb[`ESB_BIT] = eventSummary;
        stb[`OPER_BIT] = operSummary;
        mss = |(stb & cur_ff.service_request_enable & `SRE_RD_MASK);
        stb[`MSS_BIT] = mss;
    end

    assign clearHit = (cmd == CMD_DCL) || (cmd == CMD_SDC && listenAddr);

    always_comb begin
        nxt_cur = cur_ff;
        nxt_cur.replyValid = 1'b0;
        nxt_cur.talkValid = 1'b0;
        nxt_cur.chanTrigger = '0;
        nxt_cur.errPush = 1'b0;
        nxt_cur.parserReset = 1'b0;
        nxt_cur.outFlush = 1'b0;
        nxt_cur.abortOps = 1'b0;
        nxt_cur.mss = mss;
        if (cur_ff.cnt != 33'h0) begin
            nxt_cur.cnt = cur_ff.cnt - 33'h1;
        end
        if (clearHit) begin
            nxt_cur.abortOps = 1'b1;
            nxt_cur.parserReset = 1'b1;
            nxt_cur.outFlush = 1'b1;
            if (cur_ff.exec == ST_WAIT) begin
                nxt_cur.exec = ST_IDLE;
            end
        end else begin
            unique case (cur_ff.exec)
                ST_WAIT: begin
                    if (!opsPending) begin
                        nxt_cur.exec = ST_IDLE;
                    end
                end
                ST_TEST: begin
                    if (cur_ff.cnt == 33'h0) begin
                        nxt_cur.exec = ST_IDLE;
                        nxt_cur.replyValid = 1'b1;
                        nxt_cur.replyData = testFail ? `TST_FAIL_CODE : `TST_PASS_CODE;
                    end
                end
                ST_IDLE: begin
                    unique case (cmd)
                        CMD_SRE_WR: nxt_cur.service_request_enable = cmdData & `SRE_RD_MASK;
                        CMD_SRE_RD: begin
                            nxt_cur.replyValid = 1'b1;
                            nxt_cur.replyData = cur_ff.service_request_enable & `SRE_RD_MASK;
                        end
                        CMD_STB_RD: begin
                            nxt_cur.replyValid = 1'b1;
                            nxt_cur.replyData = stb;
                        end
                        CMD_TST: begin
                            nxt_cur.exec = ST_TEST;
                            nxt_cur.cnt = usbOption ? 33'(TST_USB_CYCLES)
                                                    : 33'(TST_CYCLES);
                        end
                        CMD_WAI: begin
                            if (opsPending) begin
                                nxt_cur.exec = ST_WAIT;
                            end
                        end
                        default: begin
                        end
                    endcase
                end
            endcase
        end
        // Bus-level messages act regardless of the command hold
        unique case (cmd)
            CMD_TRG, CMD_GET: begin
                if (!trigSourceBus || chanWaiting == '0) begin
                    nxt_cur.errPush = 1'b1;
                    nxt_cur.errCode = `ERR_TRIG_IGNORED;
                end else begin
                    nxt_cur.chanTrigger = chanWaiting;
                end
            end
            CMD_GTL: begin
                nxt_cur.remote = 1'b0;
                nxt_cur.locked = 1'b0;
                nxt_cur.freeRun = 1'b1;
            end
            CMD_LLO: nxt_cur.locked = 1'b1;
            CMD_SPE: begin
                nxt_cur.serialPoll = 1'b1;
                nxt_cur.spSent = 1'b0;
            end
            CMD_SPD: nxt_cur.serialPoll = 1'b0;
            default: begin
            end
        endcase
        if (cmd != CMD_NONE && cmd != CMD_GTL) begin
            nxt_cur.remote = 1'b1;
            nxt_cur.freeRun = 1'b0;
        end
        if (talkReq && talkAddr) begin
            if (cur_ff.serialPoll) begin
                if (!cur_ff.spSent) begin
                    nxt_cur.talkValid = 1'b1;
                    nxt_cur.talkData = stb;
                    nxt_cur.spSent = 1'b1;
                end
            end else begin
                nxt_cur.talkValid = 1'b1;
                nxt_cur.talkData = devData;
            end
        end
        nxt_cur.hold = (nxt_cur.exec != ST_IDLE);
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            cur_ff <= '{service_request_enable: 8'h00, exec: ST_IDLE, cnt: 33'h0, replyValid: 1'b0,
                        replyData: 8'h00, talkValid: 1'b0, talkData: 8'h00,
                        serialPoll: 1'b0, spSent: 1'b0, chanTrigger: '0,
                        errPush: 1'b0, errCode: 16'h0, parserReset: 1'b0,
                        outFlush: 1'b0, abortOps: 1'b0, remote: 1'b0,
                        locked: 1'b0, freeRun: 1'b1, mss: 1'b0, hold: 1'b0};
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    poll_responder u_poll (
        .sys_clk    (sys_clk),
        .resetn     (resetn),
        .ppcCmd     (cmd == CMD_PPC),
        .ppuCmd     (cmd == CMD_PPU),
        .listenAddr (listenAddr),
        .secValid   (secValid),
        .secByte    (secByte),
        .pollActive (pollActive),
        .rsv        (mss),
        .ppData     (ppData),
        .ppOen      (ppOen)
    );

    assign replyValid = cur_ff.replyValid;
    assign replyData = cur_ff.replyData;
    assign talkValid = cur_ff.talkValid;
    assign talkData = cur_ff.talkData;
    assign chanTrigger = cur_ff.chanTrigger;
    assign errPush = cur_ff.errPush;
    assign errCode = cur_ff.errCode;
    assign cmdHold = cur_ff.hold;
    assign parserReset = cur_ff.parserReset;
    assign outFlush = cur_ff.outFlush;
    assign abortOps = cur_ff.abortOps;
    assign remoteMode = cur_ff.remote;
    assign localKeyLocked = cur_ff.locked;
    assign freeRun = cur_ff.freeRun;
    assign srqPending = cur_ff.mss;

endmodule : gpib_status_poll

// File: design/status_poll_defs.svh
// Purpose: Constants for the instrument status and bus-command logic.
// Assumes: 40 MHz sys_clk.
// Notes:   Command codes are internal encodings on the command port.
`ifndef STATUS_POLL_DEFS_SVH
`define STATUS_POLL_DEFS_SVH

`define MSS_BIT          6
`define SRE_RD_MASK      8'hbf
`define PP_ENABLE_TAG    4'h6
`define PP_DISABLE_TAG   4'h7
`define ERR_TRIG_IGNORED 16'hff2d
`define TST_PASS_CODE    8'h30
`define TST_FAIL_CODE    8'h31
`define TST_TIME_S       60
`define TST_TIME_USB_S   120
`define CLK_HZ           40000000
`define DEPDEV_BIT       1
`define ERRQ_BIT         2
`define QUES_BIT         3
`define MAV_BIT          4
`define ESB_BIT          5
`define OPER_BIT         7
`define NUM_CHAN         2

`endif

// File: design/status_poll_pkg.sv
// Purpose: Types for the instrument status and bus-command logic.
// Assumes: Constants come from status_poll_defs.svh.
// Notes:   Command codes are this block's own encoding.
package status_poll_pkg;

    typedef enum logic [3:0] {
        CMD_NONE,
        CMD_SRE_WR,
        CMD_SRE_RD,
        CMD_STB_RD,
        CMD_TRG,
        CMD_GET,
        CMD_TST,
        CMD_WAI,
        CMD_DCL,
        CMD_SDC,
        CMD_GTL,
        CMD_LLO,
        CMD_PPC,
        CMD_PPU,
        CMD_SPE,
        CMD_SPD
    } cmd_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT,
        ST_TEST
    } exec_t;

endpackage : status_poll_pkg

// File: design/poll_responder.sv
// Purpose: Parallel poll configuration and line drive.
// Assumes: Secondary byte arrives as one strobe after the configure command.
// Notes:   Open-drain style data line, low-true enable.
`timescale 1ns/1ps
`include "status_poll_defs.svh"

module poll_responder (
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       resetn,
    // Commands
    input  wire logic       ppcCmd,
    input  wire logic       ppuCmd,
    input  wire logic       listenAddr,
    input  wire logic       secValid,
    input  wire logic [7:0] secByte,
    // Poll
    input  wire logic       pollActive,
    input  wire logic       rsv,
    output logic      [7:0] ppData,
    output logic      [7:0] ppOen
);
    typedef struct packed {
        logic       armed;
        logic       enabled;
        logic       sense;
        logic [2:0] line;
        logic [7:0] data;
        logic [7:0] oen;
    } pp_state_t;

    pp_state_t cur_ff;
    pp_state_t nxt_cur;

    always_comb begin
        nxt_cur = cur_ff;
        nxt_cur.data = 8'h00;
        nxt_cur.oen = 8'hff;
        if (secValid && cur_ff.armed) begin
            nxt_cur.armed = 1'b0;
            if (secByte[7:4] == `PP_ENABLE_TAG) begin
                nxt_cur.enabled = 1'b1;
                nxt_cur.sense = secByte[3];
                nxt_cur.line = secByte[2:0];
            end else if (secByte[7:4] == `PP_DISABLE_TAG && secByte[3:0] == 4'h0) begin
                nxt_cur.enabled = 1'b0;
            end
        end
        // A new configure in the cycle a byte is taken re-arms
        if (ppcCmd && listenAddr) begin
            nxt_cur.armed = 1'b1;
        end
        if (ppuCmd) begin
            nxt_cur.enabled = 1'b0;
            nxt_cur.armed = 1'b0;
        end
        // Sense 1 drives line set when service wanted; sense 0 when not
        if (pollActive && cur_ff.enabled && (cur_ff.sense == rsv)) begin
            nxt_cur.data[cur_ff.line] = 1'b1;
            nxt_cur.oen[cur_ff.line] = 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            cur_ff <= '{armed: 1'b0, enabled: 1'b0, sense: 1'b0, line: 3'h0,
                        data: 8'h00, oen: 8'hff};
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    assign ppData = cur_ff.data;
    assign ppOen = cur_ff.oen;

endmodule : poll_responder

// File: bench/gpib_status_poll_properties.sv
// Purpose: Port properties of the status and bus-command logic.
// Assumes: One clock, synchronous active-low reset.
// Notes:   Bound to every gpib_status_poll instance.
`timescale 1ns/1ps
`include "status_poll_defs.svh"
module status_poll_checker (
    // Clock and reset
    input wire logic                  sys_clk,
    input wire logic                  resetn,
    // Requests
    input wire status_poll_pkg::cmd_t cmd,
    input wire logic                  listenAddr,
    input wire logic                  trigSourceBus,
    input wire logic  [`NUM_CHAN-1:0] chanWaiting,
    input wire logic                  opsPending,
    // Results
    input wire logic                  replyValid,
    input wire logic            [7:0] replyData,
    input wire logic  [`NUM_CHAN-1:0] chanTrigger,
    input wire logic                  errPush,
    input wire logic           [15:0] errCode,
    input wire logic                  cmdHold,
    input wire logic                  parserReset,
    input wire logic                  outFlush,
    input wire logic                  abortOps,
    input wire logic                  remoteMode,
    input wire logic                  localKeyLocked,
    input wire logic                  freeRun,
    input wire logic            [7:0] ppOen
);
    import status_poll_pkg::*;
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);
    sequence trigReq;
        cmd == CMD_TRG || cmd == CMD_GET;
    endsequence
    sequence clearReq;
        cmd == CMD_DCL || (cmd == CMD_SDC && listenAddr);
    endsequence
    sequence clearDone;
        parserReset && outFlush && abortOps;
    endsequence

    mask_read_a: assert property (cmd == CMD_SRE_RD && !cmdHold |=> replyValid && !replyData[6])
        else $error("mask read shows bit 6");
    trig_fire_a: assert property (trigReq ##0 (trigSourceBus && |chanWaiting)
        |=> chanTrigger == $past(chanWaiting) && !errPush) else $error("trigger not fired");
    trig_refuse_a: assert property (trigReq ##0 (!trigSourceBus || chanWaiting == 0)
        |=> errPush && errCode == `ERR_TRIG_IGNORED && chanTrigger == 0)
        else $error("trigger not refused");
    dev_clear_a: assert property (clearReq |=> clearDone) else $error("clear incomplete");
    sel_clear_a: assert property (cmd == CMD_SDC && !listenAddr |=> !parserReset)
        else $error("unaddressed clear taken");
    wait_hold_a: assert property (cmd == CMD_WAI && !cmdHold && opsPending |=> cmdHold)
        else $error("wait does not hold");
    held_query_a: assert property (cmd == CMD_STB_RD && cmdHold ##1 cmdHold |-> !replyValid)
        else $error("query answered while held");
    go_local_a: assert property (cmd == CMD_GTL |=> !remoteMode && freeRun)
        else $error("local not restored");
    lock_out_a: assert property (cmd == CMD_LLO |=> localKeyLocked)
        else $error("local key not locked");
    pp_unconf_a: assert property (cmd == CMD_PPU |-> ##2 ppOen == 8'hff)
        else $error("poll line still driven");
endmodule : status_poll_checker

bind gpib_status_poll status_poll_checker chk (.sys_clk, .resetn, .cmd, .listenAddr,
    .trigSourceBus, .chanWaiting, .opsPending, .replyValid, .replyData, .chanTrigger,
    .errPush, .errCode, .cmdHold, .parserReset, .outFlush, .abortOps, .remoteMode,
    .localKeyLocked, .freeRun, .ppOen);

// File: bench/bus_controller_model.sv
// Purpose: Bus controller model: commands, addressing, polls, talk requests.
// Assumes: Lines change 2 ns after a rising edge of sys_clk.
// Notes:   Released data lines show the inverse of their last value.
`timescale 1ns/1ps
module bus_controller_model (
    // Clock
    input  wire logic             sys_clk,
    // Controller lines
    output status_poll_pkg::cmd_t cmd,
    output logic            [7:0] cmdData,
    output logic                  listenAddr,
    output logic                  talkAddr,
    output logic                  secValid,
    output logic            [7:0] secByte,
    output logic                  pollActive,
    output logic                  talkReq
);
    import status_poll_pkg::*;
    initial begin
        cmd = CMD_NONE;
        {cmdData, secByte} = 16'h0;
        {listenAddr, talkAddr, secValid, pollActive, talkReq} = 5'h0;
    end
    task automatic step;
        @(posedge sys_clk);
        #2;
    endtask : step
    task automatic issue(input cmd_t c, input logic [7:0] d);
        cmd = c;
        cmdData = d;
        step();
        cmd = CMD_NONE;
        cmdData = ~d;
        step();
    endtask : issue
    task automatic lines(input logic l, t, p);
        {listenAddr, talkAddr, pollActive} = {l, t, p};
    endtask : lines
    // Listen address first, secondary byte one idle cycle after the configure
    task automatic ppConfig(input logic [7:0] b);
        listenAddr = 1'b1;
        issue(CMD_PPC, 8'h00);
        secValid = 1'b1;
        secByte = b;
        step();
        secValid = 1'b0;
        secByte = ~b;
        step();
    endtask : ppConfig
    task automatic take;
        talkReq = 1'b1;
        step();
        talkReq = 1'b0;
        step();
    endtask : take
endmodule : bus_controller_model

// File: bench/test_gpib_status_poll.sv
// Purpose: Self-checking bench for the status and bus-command logic.
// Assumes: Short self-test counts; the controller model drives the bus side.
// Notes:   Expected results are queued at request and matched by a monitor.
`timescale 1ns/1ps
`include "status_poll_defs.svh"
module test_gpib_status_poll;
    import status_poll_pkg::*;
    localparam int unsigned TST = 20;
    localparam int unsigned TST_USB = 40;
    cmd_t cmd;
    logic sys_clk, resetn, listenAddr, talkAddr, secValid, pollActive, talkReq, testFail;
    logic trigSourceBus, opsPending, usbOption, replyValid, talkValid, errPush, cmdHold;
    logic parserReset, outFlush, abortOps, remoteMode, localKeyLocked, freeRun, srqPending;
    logic devDepCond, errQueueNotEmpty, quesSummary, msgAvailable, eventSummary, operSummary;
    logic [7:0] cmdData, secByte, devData, replyData, talkData, ppData, ppOen, stat, service_request_enable, sb;
    logic [`NUM_CHAN-1:0] chanWaiting, chanTrigger, trigSeen;
    logic [15:0] errCode;
    logic [31:0] rnd;
    logic [7:0] expQ[$];
    int fails, n_compared, nErr, nClr, expErr;

    assign {operSummary, eventSummary, msgAvailable} = {stat[7], stat[5], stat[4]};
    assign {quesSummary, errQueueNotEmpty, devDepCond} = stat[3:1];

    gpib_status_poll #(.TST_CYCLES(TST), .TST_USB_CYCLES(TST_USB)) dut (.sys_clk, .resetn,
        .cmd, .cmdData, .listenAddr, .talkAddr, .secValid, .secByte, .devDepCond,
        .errQueueNotEmpty, .quesSummary, .msgAvailable, .eventSummary, .operSummary,
        .trigSourceBus, .chanWaiting, .opsPending, .usbOption, .testFail, .talkReq,
        .devData, .replyValid, .replyData, .talkValid, .talkData, .chanTrigger, .errPush,
        .errCode, .cmdHold, .parserReset, .outFlush, .abortOps, .remoteMode,
        .localKeyLocked, .freeRun, .srqPending, .pollActive, .ppData, .ppOen);
    bus_controller_model ctl (.sys_clk, .cmd, .cmdData, .listenAddr, .talkAddr,
        .secValid, .secByte, .pollActive, .talkReq);

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr
    function automatic logic [7:0] stbOf(input logic [7:0] s, e);
        return {s[7], |({s[7], s[5:1]} & {e[7], e[5:1]}), s[5:1], 1'b0};
    endfunction : stbOf
    task automatic check(input string what, input logic [15:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : stop_test
    // Wait for results and for the hold to drop, bounded
    task automatic settle(input int lim);
        for (int i = 0; i < lim && (expQ.size() != 0 || cmdHold !== 1'b0); i++) ctl.step();
        if (expQ.size() != 0 || cmdHold !== 1'b0) begin
            check("settled", 16'h0, 16'h1);
            stop_test();
        end
    endtask : settle

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        if (resetn) begin
            if (replyValid === 1'b1 || talkValid === 1'b1) begin
                if (expQ.size() == 0) check("spare result", 16'h1, 16'h0);
                else check("result", replyValid ? replyData : talkData, expQ.pop_front());
            end
            if (errPush === 1'b1) begin
                nErr++;
                check("errCode", errCode, `ERR_TRIG_IGNORED);
            end
            if (parserReset === 1'b1) nClr++;
            trigSeen = trigSeen | chanTrigger;
        end
    end

    initial begin
        {resetn, stat, service_request_enable, trigSourceBus, chanWaiting, opsPending, usbOption, testFail} = 0;
        {nErr, nClr, expErr, fails, n_compared} = 0;
        devData = 8'h5a;
        rnd = 32'h0444;
        repeat (10) @(posedge sys_clk);
        #2;
        resetn = 1'b1;
        ctl.step();
        check("freeRun", freeRun, 1'b1);
        for (int i = 0; i < 8; i++) begin
            rnd = lfsr(rnd);
            {stat, service_request_enable} = rnd[15:0];
            ctl.issue(CMD_SRE_WR, service_request_enable);
            expQ.push_back(service_request_enable & `SRE_RD_MASK);
            ctl.issue(CMD_SRE_RD, 8'h00);
            expQ.push_back(stbOf(stat, service_request_enable));
            ctl.issue(CMD_STB_RD, 8'h00);
            settle(10);
            check("srqPending", srqPending, stbOf(stat, service_request_enable) >> 6 & 8'h1);
        end
        $display("test status done");
        for (int i = 0; i < 8; i++) begin
            rnd = lfsr(rnd);
            trigSourceBus = i[0];
            chanWaiting = i[1] ? (rnd[1:0] | 2'b01) : 2'b00;
            expErr += int'(!(i[0] && i[1]));
            trigSeen = 0;
            ctl.issue(i[2] ? CMD_GET : CMD_TRG, 8'h00);
            check("chanTrigger", trigSeen, (i[0] && i[1]) ? chanWaiting : 2'b00);
        end
        check("refused triggers", nErr, expErr);
        $display("test trigger done");
        expQ.push_back(`TST_PASS_CODE);
        ctl.issue(CMD_TST, 8'h00);
        ctl.issue(CMD_STB_RD, 8'h00);
        settle(TST + 10);
        {usbOption, testFail} = 2'b11;
        expQ.push_back(`TST_FAIL_CODE);
        ctl.issue(CMD_TST, 8'h00);
        repeat (TST + 4) ctl.step();
        check("long test holding", cmdHold, 1'b1);
        settle(TST_USB);
        $display("test self test done");
        opsPending = 1'b1;
        ctl.issue(CMD_WAI, 8'h00);
        ctl.issue(CMD_SRE_RD, 8'h00);
        check("cmdHold", cmdHold, 1'b1);
        opsPending = 1'b0;
        settle(10);
        opsPending = 1'b1;
        ctl.issue(CMD_WAI, 8'h00);
        ctl.issue(CMD_DCL, 8'h00);
        settle(5);
        ctl.issue(CMD_SDC, 8'h00);
        ctl.lines(1'b1, 1'b0, 1'b0);
        ctl.issue(CMD_SDC, 8'h00);
        check("clears taken", nClr, 2);
        opsPending = 1'b0;
        ctl.issue(CMD_LLO, 8'h00);
        check("locked", {localKeyLocked, remoteMode}, 2'b11);
        ctl.issue(CMD_GTL, 8'h00);
        check("local", {remoteMode, freeRun}, 2'b01);
        $display("test wait clear local done");
        ctl.lines(1'b1, 1'b0, 1'b1);
        sb = stbOf(stat, service_request_enable);
        for (int i = 0; i < 2; i++) begin
            rnd = lfsr(rnd);
            ctl.ppConfig({4'h6, i[0], rnd[2:0]});
            ctl.step();
            check("ppOen", ppOen, (i[0] == sb[6]) ? 8'(~(8'h01 << rnd[2:0])) : 8'hff);
            check("ppData", ppData[rnd[2:0]], i[0] == sb[6]);
        end
        ctl.ppConfig(8'h70);
        ctl.step();
        check("ppOen off", ppOen, 8'hff);
        ctl.ppConfig(8'h6a);
        ctl.issue(CMD_PPU, 8'h00);
        check("ppOen unconf", ppOen, 8'hff);
        $display("test parallel poll done");
        ctl.lines(1'b0, 1'b1, 1'b0);
        ctl.issue(CMD_SPE, 8'h00);
        expQ.push_back(sb);
        ctl.take();
        ctl.take();
        ctl.issue(CMD_SPD, 8'h00);
        expQ.push_back(devData);
        ctl.take();
        settle(10);
        $display("test serial poll done");
        stop_test();
    end

    initial begin
        repeat (20000) @(posedge sys_clk);
        check("run finished", 16'h0, 16'h1);
        stop_test();
    end
endmodule : test_gpib_status_poll
